// >>> rtl/act_pkg.sv
package act_pkg;

  // Channel and comparator counts
  localparam int ACT_NCH = 26;
  localparam int ACT_NCMP = 4;
  localparam int ACT_NTRIG = 13;
  localparam int ACT_AW = 10;

  // Register byte addresses (one 32-bit word each)
  localparam logic [9:0] ACT_MODE_HI = 10'h000;
  localparam logic [9:0] ACT_IRQ_EN_LO = 10'h004;
  localparam logic [9:0] ACT_IRQ_EN_HI = 10'h008;
  localparam logic [9:0] ACT_STAT_LO = 10'h00C;
  localparam logic [9:0] ACT_STAT_HI = 10'h010;
  // Regions picked by the upper address bits
  localparam logic [3:0] ACT_TRIG_REGION = 4'h1;
  localparam logic [3:0] ACT_CMP_REGION = 4'h2;
  localparam logic [2:0] ACT_BUF_REGION = 3'h2;
  // Word offsets inside one comparator's group
  localparam logic [1:0] ACT_CMP_CON = 2'h0;
  localparam logic [1:0] ACT_CMP_LO = 2'h1;
  localparam logic [1:0] ACT_CMP_HI = 2'h2;
  localparam logic [1:0] ACT_CMP_CHEN = 2'h3;

  // Field layout and masks
  localparam logic [15:0] ACT_MODE_MASK = 16'h000F;
  localparam logic [15:0] ACT_HI_MASK = 16'h03FF;
  localparam logic [15:0] ACT_TRIG_MASK = 16'h1F1F;
  localparam logic [15:0] ACT_CMP_WMASK = 16'h00DF;
  localparam int ACT_MODE_DSEL25 = 3;
  localparam int ACT_MODE_SIGN25 = 2;
  localparam int ACT_MODE_DSEL24 = 1;
  localparam int ACT_MODE_SIGN24 = 0;
  localparam int ACT_TRIG_ODD_LSB = 8;
  localparam int ACT_EVCH_LSB = 8;
  localparam int ACT_CMP_EN = 7;
  localparam int ACT_CMP_IRQ = 6;
  localparam int ACT_CMP_STAT = 5;
  localparam int ACT_CMP_INSIDE = 4;
  localparam int ACT_CMP_GE_HI = 3;
  localparam int ACT_CMP_LT_HI = 2;
  localparam int ACT_CMP_GE_LO = 1;
  localparam int ACT_CMP_LT_LO = 0;
  localparam logic [15:0] ACT_RESET_VAL = 16'h0000;

  // One finished conversion from the converter core
  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [15:0] data;
  } act_result_s;

  // Trigger sources from neighbouring peripherals (same clock)
  typedef struct packed {
    logic seq;
    logic [1:0] clc;
    logic multi_cc;
    logic [6:0] sccp;
    logic [15:0] pwm;
    logic level_sw;
    logic common_sw;
  } act_trig_src_s;

endpackage : act_pkg

// >>> rtl/act_channel_ctrl.sv
`timescale 1ns/1ps
module act_channel_ctrl
  import act_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ACT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core side
  input wire act_result_s conv_result,
  input wire act_trig_src_s trig_src,
  input wire logic ext_trig_pin,
  output logic [ACT_NCH-1:0] conv_request,
  output logic [1:0] differential_select,
  output logic [1:0] signed_select,
  // Interrupt pulses
  output logic common_irq,
  output logic [ACT_NCH-1:0] chan_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [3:0] mode_hi;
  logic [ACT_NCH-1:0] irq_enable_bits;
  logic [ACT_NCH-1:0] result_ready_flag;
  logic [15:0] trig_word [ACT_NTRIG];
  logic [15:0] cmp_con [ACT_NCMP];
  logic [15:0] low_threshold [ACT_NCMP];
  logic [15:0] high_threshold [ACT_NCMP];
  logic [ACT_NCH-1:0] cmp_chan_en [ACT_NCMP];
  logic [15:0] channel_result_buffer [ACT_NCH];
  logic ext_meta;
  logic ext_sync;
  logic [31:0] next_prdata;
  logic next_err;
  logic wr_go;
  logic rd_go;
  logic [ACT_NCMP-1:0] cmp_hit;
  logic [ACT_NCMP-1:0] evch_read;
  logic [ACT_NCMP-1:0] cmp_wr;
  logic [ACT_NCH-1:0] buf_read;
  logic [31:0] src_vec;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Condition check shared by all four comparators
  function automatic logic cond_hit(input logic [15:0] con, input logic [15:0] res,
                                    input logic [15:0] lo, input logic [15:0] hi);
    logic ge_lo;
    logic ge_hi;
    ge_lo = (res >= lo);
    ge_hi = (res >= hi);
    cond_hit = (con[ACT_CMP_INSIDE] && ge_lo && !ge_hi)
      || (con[ACT_CMP_GE_HI] && ge_hi)
      || (con[ACT_CMP_LT_HI] && !ge_hi)
      || (con[ACT_CMP_GE_LO] && ge_lo)
      || (con[ACT_CMP_LT_LO] && !ge_lo);
  endfunction : cond_hit

  // Trigger code of one channel from the paired select words
  function automatic logic [4:0] chan_code(input logic [15:0] word, input logic odd);
    chan_code = odd ? word[ACT_TRIG_ODD_LSB +: 5] : word[4:0];
  endfunction : chan_code

  // Result-buffer region decode, used by read data and by flag clearing
  function automatic logic is_buf(input logic [ACT_AW-1:0] a);
    is_buf = (a[9:7] == ACT_BUF_REGION) && (a[6:2] < 5'(ACT_NCH));
  endfunction : is_buf

  //////////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait state, so read data comes from a flop
  assign wr_go = psel && penable && pready && pwrite;
  assign rd_go = psel && penable && pready && !pwrite;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      prdata <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= psel && penable && !pready && next_err;
    end
  end

  // Read mux; unmapped words read zero and answer with an error
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == ACT_MODE_HI)
      next_prdata[3:0] = mode_hi;
    else if (paddr == ACT_IRQ_EN_LO)
      next_prdata[15:0] = irq_enable_bits[15:0];
    else if (paddr == ACT_IRQ_EN_HI)
      next_prdata[9:0] = irq_enable_bits[ACT_NCH-1:16];
    else if (paddr == ACT_STAT_LO)
      next_prdata[15:0] = result_ready_flag[15:0];
    else if (paddr == ACT_STAT_HI)
      next_prdata[9:0] = result_ready_flag[ACT_NCH-1:16];
    else if (paddr[9:6] == ACT_TRIG_REGION && paddr[5:2] < 4'(ACT_NTRIG))
      next_prdata[15:0] = trig_word[paddr[5:2]] & ACT_TRIG_MASK;
    else if (paddr[9:6] == ACT_CMP_REGION)
    begin
      unique case (paddr[3:2])
        ACT_CMP_CON: next_prdata[15:0] = cmp_con[paddr[5:4]];
        ACT_CMP_LO: next_prdata[15:0] = low_threshold[paddr[5:4]];
        ACT_CMP_HI: next_prdata[15:0] = high_threshold[paddr[5:4]];
        ACT_CMP_CHEN: next_prdata[ACT_NCH-1:0] = cmp_chan_en[paddr[5:4]];
      endcase
    end
    else if (is_buf(paddr))
      next_prdata[15:0] = channel_result_buffer[paddr[6:2]];
    else
      next_err = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_hi <= ACT_RESET_VAL[3:0];
      irq_enable_bits <= '0;
      for (int i = 0; i < ACT_NTRIG; i++)
        trig_word[i] <= ACT_RESET_VAL;
      for (int x = 0; x < ACT_NCMP; x++)
      begin
        low_threshold[x] <= ACT_RESET_VAL;
        high_threshold[x] <= ACT_RESET_VAL;
        cmp_chan_en[x] <= '0;
      end
    end
    else if (wr_go)
    begin
      if (paddr == ACT_MODE_HI)
        mode_hi <= pwdata[3:0] & ACT_MODE_MASK[3:0];
      if (paddr == ACT_IRQ_EN_LO)
        irq_enable_bits[15:0] <= pwdata[15:0];
      if (paddr == ACT_IRQ_EN_HI)
        irq_enable_bits[ACT_NCH-1:16] <= pwdata[9:0] & ACT_HI_MASK[9:0];
      if (paddr[9:6] == ACT_TRIG_REGION && paddr[5:2] < 4'(ACT_NTRIG))
        trig_word[paddr[5:2]] <= pwdata[15:0] & ACT_TRIG_MASK;
      if (paddr[9:6] == ACT_CMP_REGION)
      begin
        if (paddr[3:2] == ACT_CMP_LO)
          low_threshold[paddr[5:4]] <= pwdata[15:0];
        if (paddr[3:2] == ACT_CMP_HI)
          high_threshold[paddr[5:4]] <= pwdata[15:0];
        if (paddr[3:2] == ACT_CMP_CHEN)
          cmp_chan_en[paddr[5:4]] <= pwdata[ACT_NCH-1:0];
      end
    end
  end

  // Mode bits of channels 24 and 25 drive the analog front end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      differential_select <= 2'h0;
      signed_select <= 2'h0;
    end
    else
    begin
      differential_select <= {mode_hi[ACT_MODE_DSEL25], mode_hi[ACT_MODE_DSEL24]};
      signed_select <= {mode_hi[ACT_MODE_SIGN25], mode_hi[ACT_MODE_SIGN24]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result buffers and ready flags
  always_ff @(posedge pclk)
  begin
    if (conv_result.valid && conv_result.chan < 5'(ACT_NCH))
      channel_result_buffer[conv_result.chan] <= conv_result.data;
  end

  always_comb
  begin
    buf_read = '0;
    if (rd_go && is_buf(paddr))
      buf_read[paddr[6:2]] = 1'b1;
  end

  // A new result in the same cycle as a read keeps the flag set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_ready_flag <= '0;
    else
      for (int c = 0; c < ACT_NCH; c++)
        if (conv_result.valid && conv_result.chan == 5'(c))
          result_ready_flag[c] <= 1'b1;
        else if (buf_read[c])
          result_ready_flag[c] <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Digital comparators
  always_comb
  begin
    evch_read = '0;
    cmp_wr = '0;
    cmp_hit = '0;
    for (int x = 0; x < ACT_NCMP; x++)
    begin
      evch_read[x] = rd_go && paddr[9:6] == ACT_CMP_REGION && paddr[5:4] == 2'(x)
        && paddr[3:2] == ACT_CMP_CON;
      cmp_wr[x] = wr_go && paddr[9:6] == ACT_CMP_REGION && paddr[5:4] == 2'(x)
        && paddr[3:2] == ACT_CMP_CON;
      cmp_hit[x] = conv_result.valid && cmp_con[x][ACT_CMP_EN]
        && conv_result.chan < 5'(ACT_NCH)
        && cmp_chan_en[x][conv_result.chan]
        && cond_hit(cmp_con[x], conv_result.data,
                    low_threshold[x], high_threshold[x]);
    end
  end

  // Compare is unsigned; signed channels should be given signed-aware thresholds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int x = 0; x < ACT_NCMP; x++)
        cmp_con[x] <= ACT_RESET_VAL;
    else
      for (int x = 0; x < ACT_NCMP; x++)
      begin
        if (cmp_wr[x])
          cmp_con[x][7:0] <= (pwdata[7:0] & ACT_CMP_WMASK[7:0])
            | (cmp_con[x][7:0] & ~ACT_CMP_WMASK[7:0]);
        // Switching off beats a same-cycle event; an event is never lost to a read or to a write that keeps the enable set
        if (cmp_wr[x] && !pwdata[ACT_CMP_EN])
          cmp_con[x][ACT_CMP_STAT] <= 1'b0;
        else if (cmp_hit[x])
        begin
          cmp_con[x][ACT_CMP_STAT] <= 1'b1;
          cmp_con[x][ACT_EVCH_LSB +: 5] <= conv_result.chan;
        end
        else if (evch_read[x])
          cmp_con[x][ACT_CMP_STAT] <= 1'b0;
      end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trigger routing; external pin is synchronised before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end
    else
    begin
      ext_meta <= ext_trig_pin;
      ext_sync <= ext_meta;
    end
  end

  // Index equals trigger code; slots 0 and 3 never fire
  assign src_vec = {ext_sync, trig_src.seq, trig_src.clc, trig_src.multi_cc,
                    trig_src.sccp, trig_src.pwm, 1'b0,
                    trig_src.level_sw, trig_src.common_sw, 1'b0};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conv_request <= '0;
    else
      for (int c = 0; c < ACT_NCH; c++)
        conv_request[c] <= src_vec[chan_code(trig_word[c/2], c[0])];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses, one cycle after the causing event
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      common_irq <= 1'b0;
      chan_irq <= '0;
    end
    else
    begin
      for (int c = 0; c < ACT_NCH; c++)
        chan_irq[c] <= conv_result.valid && conv_result.chan == 5'(c)
          && irq_enable_bits[c];
      common_irq <= (conv_result.valid && conv_result.chan < 5'(ACT_NCH)
        && irq_enable_bits[conv_result.chan])
        || |(cmp_hit & {cmp_con[3][ACT_CMP_IRQ], cmp_con[2][ACT_CMP_IRQ],
                        cmp_con[1][ACT_CMP_IRQ], cmp_con[0][ACT_CMP_IRQ]});
    end
  end

endmodule : act_channel_ctrl

// >>> verification/act_channel_ctrl_checker.sv
`timescale 1ns/1ps
module act_channel_ctrl_checker
  import act_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ACT_AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Converter side
  input wire act_result_s conv_result,
  input wire act_trig_src_s trig_src,
  input wire logic ext_trig_pin,
  input wire logic [ACT_NCH-1:0] conv_request,
  input wire logic [1:0] differential_select,
  input wire logic [1:0] signed_select,
  input wire logic common_irq,
  input wire logic [ACT_NCH-1:0] chan_irq
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wcom;
  logic rd_done;
  localparam logic [ACT_NCH-1:0] ONE = ACT_NCH'(1);
  // Committed write and read, as the bus sees them
  assign wcom = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;
  a_differential_select_by_write: assert property (
    $changed(differential_select) |-> $past(wcom && paddr == ACT_MODE_HI, 2))
    else $error("differential select moved without a write");
  a_sign_by_write: assert property (
    $changed(signed_select) |-> $past(wcom && paddr == ACT_MODE_HI, 2))
    else $error("signed select moved without a write");
  a_irq_chan_match: assert property (
    chan_irq != 0 |-> $past(conv_result.valid) && chan_irq == ONE << $past(conv_result.chan))
    else $error("channel interrupt without matching result");
  a_irq_both_kinds: assert property (
    chan_irq != 0 |-> common_irq)
    else $error("channel interrupt without common interrupt");
  a_common_has_cause: assert property (
    common_irq |-> $past(conv_result.valid))
    else $error("common interrupt without a result");
  a_ready_hi_zero: assert property (
    rd_done && paddr == ACT_STAT_HI |-> prdata[31:10] == 22'h0)
    else $error("unused ready bits not zero");
  a_trig_spare_zero: assert property (
    rd_done && paddr[9:6] == ACT_TRIG_REGION |-> (prdata & ~32'h1F1F) == 32'h0)
    else $error("unused trigger select bits not zero");
  a_no_stray_trig: assert property (
    conv_request != 0 |-> $past(trig_src != 0) || $past(ext_trig_pin, 3))
    else $error("conversion request without a source");
endmodule : act_channel_ctrl_checker

// >>> verification/act_channel_ctrl_tb.sv
`timescale 1ns/1ps
module act_channel_ctrl_tb
  import act_pkg::*;
  ;
  logic pclk, presetn, psel, penable, pwrite, ext_trig_pin, pready, pslverr, common_irq, e;
  logic [ACT_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, q, w, v;
  act_result_s conv_result;
  act_trig_src_s trig_src;
  logic [ACT_NCH-1:0] conv_request, chan_irq, irq_en_m, chen_m;
  logic [1:0] differential_select, signed_select;
  logic [7:0] ctl_m;
  logic ev, stat_m;
  logic [4:0] evch_m;
  int n_mismatch, check_count, c, k, b, lo, hi;
  logic [9:0] base;
  logic [15:0] dv [4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
  act_channel_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_result, .trig_src, .ext_trig_pin, .conv_request,
    .differential_select, .signed_select, .common_irq, .chan_irq);
  // Free-running bus clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Bus cycle; the answer is taken at the rising edge where pready is high
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_mismatch++;
        wrap_up();
      end
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never re-drives psel in this time step
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [9:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask : rd
  // One result from the core, with the comparator model beside it
  task automatic conv(input int ch, input logic [15:0] d);
    ev = ctl_m[7] && chen_m[ch] && ((ctl_m[4] && d >= lo && d < hi) || (ctl_m[3] && d >= hi)
      || (ctl_m[2] && d < hi) || (ctl_m[1] && d >= lo) || (ctl_m[0] && d < lo));
    stat_m = stat_m | ev;
    if (ev)
      evch_m = 5'(ch);
    conv_result <= '{1'b1, 5'(ch), d};
    @(posedge pclk);
    conv_result <= '0;
    @(negedge pclk);
    chk("chan_irq", chan_irq, irq_en_m[ch] ? 32'h1 << ch : 32'h0);
    chk("common_irq", common_irq, irq_en_m[ch] | (ev & ctl_m[6]));
    @(posedge pclk);
    rd(10'h100 + 10'(4 * ch), {16'h0, d}, "result");
    rd(ACT_STAT_LO, 32'h0, "ready_lo");
  endtask : conv
  ////////////////////////////////////////
  initial
  begin
    {presetn, psel, penable, pwrite, ext_trig_pin, paddr, pwdata} = '0;
    conv_result = '0;
    trig_src = '0;
    {n_mismatch, check_count, ctl_m, chen_m, stat_m, evch_m, lo, hi} = '0;
    void'($urandom(32'h38e4));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values, then mode bits and interrupt enables
    foreach (dv[i])
      rd(10'(4 * i), 32'h0, "reset");
    for (k = 0; k < 4; k++)
    begin
      v = $urandom;
      apb(1'b1, ACT_MODE_HI, v);
      rd(ACT_MODE_HI, v & 32'hF, "mode");
      chk("differential", differential_select, {v[3], v[1]});
      chk("sign", signed_select, {v[2], v[0]});
    end
    w = $urandom;
    v = $urandom;
    apb(1'b1, ACT_IRQ_EN_LO, w);
    apb(1'b1, ACT_IRQ_EN_HI, v);
    irq_en_m = {v[9:0], w[15:0]};
    rd(ACT_IRQ_EN_HI, v & 32'h3FF, "irq_en_hi");
    apb(1'b0, 10'h3FC, 32'h0);
    chk("slverr", e, 1'b1);
    // Result ready flag set by a result and cleared by the buffer read
    c = $urandom_range(25);
    conv_result <= '{1'b1, 5'(c), 16'h0ABC};
    @(posedge pclk);
    conv_result <= '0;
    @(posedge pclk);
    rd(c < 16 ? ACT_STAT_LO : ACT_STAT_HI, 32'h1 << (c % 16), "ready");
    // Read the buffer so no stale flag is left for the later status checks
    rd(10'h100 + 10'(4 * c), 32'h0ABC, "result_first");
    for (k = 0; k < 8; k++)
      conv($urandom_range(15), 16'($urandom));
    // Every trigger code on a random channel
    for (k = 0; k < 32; k++)
    begin
      c = $urandom_range(25);
      base = 10'h040 + 10'(4 * (c / 2));
      apb(1'b1, base, k << (8 * (c % 2)));
      rd(base, k << (8 * (c % 2)), "trig_sel");
      b = k < 3 ? k - 1 : k - 2;
      ext_trig_pin <= k == 31;
      trig_src <= (k == 0 || k == 3) ? '1 : (k == 31 ? '0 : 29'h1 << b);
      repeat (k == 31 ? 4 : 1) @(posedge pclk);
      trig_src <= '0;
      ext_trig_pin <= 1'b0;
      @(negedge pclk);
      chk("request", conv_request, (k == 0 || k == 3) ? 0 : 32'h1 << c);
      repeat (4) @(posedge pclk);
      apb(1'b1, base, 32'h0);
    end
    // Comparator modes around both thresholds
    base = 10'h080 + 10'(16 * $urandom_range(3));
    c = $urandom_range(25);
    lo = 'h100;
    hi = 'h200;
    chen_m = 26'h1 << c;
    apb(1'b1, base + 10'h4, lo);
    apb(1'b1, base + 10'h8, hi);
    apb(1'b1, base + 10'hC, chen_m);
    for (k = 0; k < 20; k++)
    begin
      ctl_m = 8'h80 | (8'($urandom_range(1)) << 6) | (8'h1 << (k / 4));
      apb(1'b1, base, ctl_m);
      conv(c, dv[k % 4]);
      rd(base, {19'h0, evch_m, ctl_m[7:6], stat_m, ctl_m[4:0]}, "cmp");
      stat_m = 1'b0;
    end
    // Raise the event flag first, so switching off has something to clear
    ctl_m = 8'hC8;
    apb(1'b1, base, ctl_m);
    conv(c, 16'h0300);
    ctl_m = 8'h48;
    stat_m = 1'b0;
    apb(1'b1, base, ctl_m);
    rd(base, {19'h0, evch_m, 8'h48}, "cmp_off");
    conv(c, 16'h0300);
    ctl_m = 8'hC8;
    chen_m = '0;
    apb(1'b1, base, ctl_m);
    apb(1'b1, base + 10'hC, 32'h0);
    conv(c, 16'h0300);
    rd(base, {19'h0, evch_m, 8'hC8}, "cmp_masked");
    wrap_up();
  end
endmodule : act_channel_ctrl_tb
bind act_channel_ctrl act_channel_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .conv_result, .trig_src, .ext_trig_pin, .conv_request,
  .differential_select, .signed_select, .common_irq, .chan_irq);
